// >>> core/rss_sequencer.sv
// Relay switch sequencer: address strap, settling timer, row modes, phases
// Contract
// - Default bus address 18 unless switches differ
// - Switch 0-30 stand-alone, 31-60 master
// - Master address is switch value minus 30
// - Switches sampled only at power-up
// - Hold largest card settling time, read-only
// - Add programmed ms delay, up to 65 s
// - Trigger during delay processed, error set
// - Matrix ready true when delay expires
// - Parameters apply to all switching until changed
// - Hardware settle query reports longest card time
// - Machine status word holds programmed delay
// - Self-test at power-up and on command
// - Memory fail sets error until bus operation
// - Self-test runs on all units together
// - Switch value 99 lights every lamp
// - Restore defaults, master propagates to loop
// - Row holds one of three modes
// - Setup change applied in four phases
// - Skip phases of unused modes
// - Row modes sent to all units
// - Wait hardware settle after each setup
// - Matrix ready false when relays start
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int ROWS = 8,
  parameter int COLS = 8,
  parameter int TICK_CYCLES = RSS_TICK_CYCLES,
  parameter int TEST_CYCLES = RSS_SELFTEST_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Rear switches, card settle time in cycles, memory test result
  input wire logic [6:0] addr_switch_i,
  input wire logic [15:0] card_settle_i,
  input wire logic mem_test_ok_i,
  // Relay drive and loop broadcast
  output logic [ROWS*COLS-1:0] relay_o,
  output logic [ROWS*2-1:0] loop_modes_o,
  output logic loop_selftest_o,
  output logic loop_defaults_o,
  // Indications
  output logic matrix_ready_o,
  output logic error_o,
  output logic lamps_all_o,
  output logic [6:0] bus_addr_o,
  output logic master_o
);
  localparam int N = ROWS * COLS;

  typedef struct packed {
    logic [2:0] sync;
    logic [20:0] sw;
    logic strap_done;
    logic [6:0] addr;
    logic master;
    logic lamps;
    logic [15:0] hw;
    logic [15:0] delay;
    logic [ROWS-1:0] mbb;
    logic [ROWS-1:0] bbm;
    logic [N-1:0] target;
    logic [N-1:0] relay;
    rss_state_t st;
    logic [15:0] cnt;
    logic in_hw;
    logic ready;
    logic err;
    logic notsettled;
    logic memfail;
    logic st_pend;
    logic loop_test;
    logic loop_def;
    logic [31:0] rdata;
    logic wreq;
    logic lamp_on;
  } rss_state_s_t;

  rss_state_s_t q;
  rss_state_s_t next_q;
  logic tick;
  logic tick_clr;

  // Row mask spread over every column of the row
  function automatic logic [N-1:0] rss_spread(input logic [ROWS-1:0] rows);
    logic [N-1:0] m;
    m = '0;
    for (int r = 0; r < ROWS; r++) begin
      m[r*COLS +: COLS] = {COLS{rows[r]}};
    end
    return m;
  endfunction

  // Interleave row modes for the loop broadcast
  function automatic logic [ROWS*2-1:0] rss_pack(input logic [ROWS-1:0] a,
                                                 input logic [ROWS-1:0] b);
    logic [ROWS*2-1:0] v;
    v = '0;
    for (int r = 0; r < ROWS; r++) begin
      v[2*r] = a[r];
      v[2*r+1] = b[r];
    end
    return v;
  endfunction

  rss_ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clear_i(tick_clr),
    .tick_o(tick)
  );

  // Held through every hardware settle interval, keeping the ms divider cleared
  assign tick_clr = q.in_hw;

  always_comb begin
    logic [N-1:0] mm;
    logic [N-1:0] bm;
    logic [N-1:0] tgt;
    logic acc;
    logic wr;
    logic rd;
    logic [ROWS-1:0] rowbit;
    logic trig;
    logic go_test;
    logic [6:0] sw3;
    mm = rss_spread(q.mbb);
    bm = rss_spread(q.bbm);
    tgt = q.target;
    sw3 = q.sw[20:14];
    next_q = q;
    // Switch pins cross three flops; a half-turned switch must not strap
    next_q.sync = {q.sync[1:0], 1'b1};
    next_q.sw = {q.sw[13:0], addr_switch_i};
    next_q.loop_test = 1'b0;
    next_q.loop_def = 1'b0;
    // Read data fetched as the request is taken, so it stands when wait drops
    acc = (avs_read_i || avs_write_i) && q.wreq;
    rd = avs_read_i && q.wreq;
    // Writes land only at the edge where waitrequest is seen low
    wr = avs_write_i && !q.wreq;
    next_q.wreq = !acc;
    rowbit = '0;
    rowbit[avs_writedata_i[RSS_ROW_LSB +: 3] % ROWS] = 1'b1;
    trig = 1'b0;
    go_test = 1'b0;
    if (!q.strap_done && q.sync[2] && q.sw[13:7] == sw3) begin
      next_q.strap_done = 1'b1;
      next_q.hw = card_settle_i;
      next_q.lamps = (sw3 == RSS_ADDR_LAMP_TEST);
      if (sw3 > RSS_ADDR_MASTER_OFS &&
          sw3 <= RSS_ADDR_MASTER_MAX) begin
        next_q.master = 1'b1;
        next_q.addr = sw3 - RSS_ADDR_MASTER_OFS;
      end else if (sw3 <= RSS_ADDR_MASTER_OFS) begin
        next_q.master = 1'b0;
        next_q.addr = sw3;
      end else begin
        next_q.master = 1'b0;
        next_q.addr = RSS_ADDR_DEFAULT;
      end
      go_test = 1'b1;
    end
    // Any bus access outside self-test ends a held memory-fail error
    if (acc && q.st != RSS_TEST) begin
      next_q.memfail = 1'b0;
    end
    if (wr) begin
      case (avs_address_i)
        RSS_OFS_CTRL: begin
          trig = avs_writedata_i[RSS_CTRL_TRIG];
          go_test = go_test || avs_writedata_i[RSS_CTRL_SELFTEST];
          if (avs_writedata_i[RSS_CTRL_CLR_ERR]) begin
            next_q.err = 1'b0;
            next_q.notsettled = 1'b0;
          end
          if (avs_writedata_i[RSS_CTRL_DEFAULTS]) begin
            next_q.delay = RSS_DELAY_RESET;
            next_q.mbb = '0;
            next_q.bbm = '0;
            next_q.err = 1'b0;
            next_q.notsettled = 1'b0;
            next_q.loop_def = q.master;
          end
        end
        RSS_OFS_DELAY: next_q.delay = (avs_writedata_i[15:0] > RSS_DELAY_MAX) ?
                                      RSS_DELAY_MAX : avs_writedata_i[15:0];
        RSS_OFS_MBB: begin
          next_q.mbb = avs_writedata_i[ROWS-1:0];
          next_q.bbm = q.bbm & ~avs_writedata_i[ROWS-1:0];
        end
        RSS_OFS_BBM: begin
          next_q.bbm = avs_writedata_i[ROWS-1:0];
          next_q.mbb = q.mbb & ~avs_writedata_i[ROWS-1:0];
        end
        RSS_OFS_ROWSEL: begin
          if (avs_writedata_i[RSS_SEL_MBB]) begin
            if (avs_writedata_i[RSS_SEL_ON]) begin
              next_q.mbb = q.mbb | rowbit;
              next_q.bbm = q.bbm & ~rowbit;
            end else begin
              next_q.mbb = q.mbb & ~rowbit;
            end
          end else if (avs_writedata_i[RSS_SEL_BBM]) begin
            if (avs_writedata_i[RSS_SEL_ON]) begin
              next_q.bbm = q.bbm | rowbit;
              next_q.mbb = q.mbb & ~rowbit;
            end else begin
              next_q.bbm = q.bbm & ~rowbit;
            end
          end
        end
        RSS_OFS_TARGET: next_q.target = avs_writedata_i[N-1:0];
        default: begin
        end
      endcase
      // Bulk writes must not leave a row in both modes
      if (avs_address_i == RSS_OFS_MBB || avs_address_i == RSS_OFS_BBM) begin
        next_q.bbm = next_q.bbm & ~next_q.mbb;
      end
    end
    if (rd) begin
      case (avs_address_i)
        RSS_OFS_DELAY: next_q.rdata = {16'h0000, q.delay};
        RSS_OFS_MBB: next_q.rdata = 32'(q.mbb);
        RSS_OFS_BBM: next_q.rdata = 32'(q.bbm);
        RSS_OFS_TARGET: next_q.rdata = 32'(q.target);
        RSS_OFS_STATUS: next_q.rdata = 32'({q.memfail, q.notsettled,
                          q.st == RSS_TEST, q.lamps, q.master, q.err,
                          q.st != RSS_IDLE, q.ready});
        RSS_OFS_HWSETTLE: next_q.rdata = {16'h0000, q.hw};
        RSS_OFS_MACHINE: next_q.rdata = {q.delay, 8'h00, q.master, q.addr};
        RSS_OFS_ADDR: next_q.rdata = {25'h0000000, q.addr};
        RSS_OFS_RELAYS: next_q.rdata = 32'(q.relay);
        default: next_q.rdata = RSS_RD_UNMAPPED;
      endcase
    end
    // Sequencer
    case (q.st)
      RSS_IDLE: begin
        if (go_test) begin
          next_q.st = RSS_TEST;
          next_q.cnt = 16'h0000;
        end else if (trig) begin
          next_q.ready = 1'b0;
          next_q.in_hw = 1'b1;
          next_q.cnt = q.hw;
          if (q.bbm != '0) begin
            next_q.st = RSS_PH1;
            next_q.relay = q.relay & ~bm;
          end else if (q.mbb != '0) begin
            next_q.st = RSS_PH2;
            next_q.relay = q.relay | (tgt & mm);
          end else begin
            next_q.st = RSS_PH4;
            next_q.relay = tgt;
          end
        end
      end
      RSS_PH1, RSS_PH2, RSS_PH3, RSS_PH4: begin
        if (q.cnt != 16'h0000) begin
          next_q.cnt = q.cnt - 16'h0001;
        end else if (q.st == RSS_PH1 && q.mbb != '0) begin
          next_q.st = RSS_PH2;
          next_q.cnt = q.hw;
          next_q.relay = q.relay | (tgt & mm);
        end else if (q.st == RSS_PH2 && q.bbm != '0) begin
          // Without break rows, opening make rows joins the last setup
          next_q.st = RSS_PH3;
          next_q.cnt = q.hw;
          next_q.relay = (q.relay & ~mm) | (tgt & mm);
        end else if (q.st != RSS_PH4) begin
          next_q.st = RSS_PH4;
          next_q.cnt = q.hw;
          next_q.relay = tgt;
        end else begin
          next_q.st = RSS_PROG;
          next_q.in_hw = 1'b0;
          next_q.cnt = q.delay;
        end
        if (trig) begin
          next_q.err = 1'b1;
        end
      end
      RSS_PROG: begin
        if (q.cnt == 16'h0000 || (tick && q.cnt == 16'h0001)) begin
          // Ready at expiry, on the tick ending the last ms
          next_q.ready = 1'b1;
          next_q.st = RSS_IDLE;
          next_q.cnt = 16'h0000;
        end else if (tick) begin
          next_q.cnt = q.cnt - 16'h0001;
        end
        if (trig) begin
          next_q.err = 1'b1;
          next_q.notsettled = 1'b1;
          next_q.ready = 1'b0;
          next_q.in_hw = 1'b1;
          next_q.cnt = q.hw;
          next_q.st = (q.bbm != '0) ? RSS_PH1 : (q.mbb != '0) ? RSS_PH2 : RSS_PH4;
          next_q.relay = (q.bbm != '0) ? (q.relay & ~bm) :
                         (q.mbb != '0) ? (q.relay | (tgt & mm)) : tgt;
        end
      end
      RSS_TEST: begin
        next_q.loop_test = (q.cnt == 16'h0000) && q.master;
        if (q.cnt == 16'(TEST_CYCLES)) begin
          next_q.st = RSS_IDLE;
          next_q.cnt = 16'h0000;
          next_q.ready = 1'b1;
          if (!mem_test_ok_i) begin
            next_q.memfail = 1'b1;
            next_q.err = 1'b1;
          end
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      default: next_q.st = RSS_IDLE;
    endcase
    if (q.memfail && !next_q.memfail) begin
      next_q.err = next_q.err && q.notsettled;
    end
    // Lamps lit by strap or during any self-test
    next_q.lamp_on = next_q.lamps || (next_q.st == RSS_TEST);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.addr <= RSS_ADDR_DEFAULT;
      q.delay <= RSS_DELAY_RESET;
      q.st <= RSS_IDLE;
      q.wreq <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wreq;
  assign relay_o = q.relay;
  assign loop_modes_o = rss_pack(q.mbb, q.bbm);
  assign loop_selftest_o = q.loop_test;
  assign loop_defaults_o = q.loop_def;
  assign matrix_ready_o = q.ready;
  assign error_o = q.err;
  assign lamps_all_o = q.lamp_on;
  assign bus_addr_o = q.addr;
  assign master_o = q.master;
endmodule // rss_sequencer
`default_nettype wire

// >>> common/rss_pkg.sv
// Package for the relay switch sequencer: map, fields, resets, timing
package rss_pkg;
  // Register byte offsets
  localparam logic [5:0] RSS_OFS_CTRL = 6'h00;
  localparam logic [5:0] RSS_OFS_DELAY = 6'h04;
  localparam logic [5:0] RSS_OFS_MBB = 6'h08;
  localparam logic [5:0] RSS_OFS_BBM = 6'h0C;
  localparam logic [5:0] RSS_OFS_ROWSEL = 6'h10;
  localparam logic [5:0] RSS_OFS_TARGET = 6'h14;
  localparam logic [5:0] RSS_OFS_STATUS = 6'h18;
  localparam logic [5:0] RSS_OFS_HWSETTLE = 6'h1C;
  localparam logic [5:0] RSS_OFS_MACHINE = 6'h20;
  localparam logic [5:0] RSS_OFS_ADDR = 6'h24;
  localparam logic [5:0] RSS_OFS_RELAYS = 6'h28;
  // Control register bit positions (write one to act)
  localparam int RSS_CTRL_TRIG = 0;
  localparam int RSS_CTRL_SELFTEST = 1;
  localparam int RSS_CTRL_DEFAULTS = 2;
  localparam int RSS_CTRL_CLR_ERR = 3;
  // Row select register field positions
  localparam int RSS_ROW_LSB = 0;
  localparam int RSS_SEL_MBB = 8;
  localparam int RSS_SEL_BBM = 9;
  localparam int RSS_SEL_ON = 10;
  // Status register bit positions
  localparam int RSS_ST_READY = 0;
  localparam int RSS_ST_BUSY = 1;
  localparam int RSS_ST_ERR = 2;
  localparam int RSS_ST_MASTER = 3;
  localparam int RSS_ST_LAMPS = 4;
  localparam int RSS_ST_TESTING = 5;
  localparam int RSS_ST_NOTSETTLED = 6;
  localparam int RSS_ST_MEMFAIL = 7;
  // Address and reset values
  localparam logic [6:0] RSS_ADDR_DEFAULT = 7'h12;
  localparam logic [6:0] RSS_ADDR_MASTER_OFS = 7'h1E;
  localparam logic [6:0] RSS_ADDR_MASTER_MAX = 7'h3C;
  localparam logic [6:0] RSS_ADDR_LAMP_TEST = 7'h63;
  localparam logic [15:0] RSS_DELAY_RESET = 16'h0000;
  localparam logic [15:0] RSS_DELAY_MAX = 16'hFDE8;
  // Timing
  localparam int RSS_CLK_HZ = 20000000;
  localparam int RSS_TICK_US = 1000;
  localparam int RSS_TICK_CYCLES = RSS_CLK_HZ / 1000000 * RSS_TICK_US;
  localparam int RSS_SELFTEST_CYCLES = 64;
  // Data bus reads of unmapped words
  localparam logic [31:0] RSS_RD_UNMAPPED = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [2:0] {
    RSS_IDLE = 3'b000,
    RSS_PH1 = 3'b001,
    RSS_PH2 = 3'b010,
    RSS_PH3 = 3'b011,
    RSS_PH4 = 3'b100,
    RSS_PROG = 3'b101,
    RSS_TEST = 3'b110
  } rss_state_t;
endpackage : rss_pkg

// >>> core/rss_ms_tick.sv
// Millisecond tick divider for the settling timer
`timescale 1ns/100ps
`default_nettype none
module rss_ms_tick
  import rss_pkg::*;
#(
  parameter int CYCLES = RSS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Restart the count
  input wire logic clear_i,
  // One-cycle pulse each period
  output logic tick_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } rss_tick_state_t;
  rss_tick_state_t q;
  rss_tick_state_t next_q;
  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (clear_i) begin
      next_q.cnt = 16'h0000;
    end else if (q.cnt == LAST) begin
      next_q.cnt = 16'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick_o = q.tick;
endmodule // rss_ms_tick
`default_nettype wire

// >>> verification/rss_seq_assertions.sv
// Checker for the relay switch sequencer top ports
`timescale 1ns/100ps
`default_nettype none
module rss_seq_checker
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  // Straps and cards
  input wire logic [6:0] addr_switch_i,
  input wire logic [15:0] card_settle_i,
  // Outputs watched
  input wire logic loop_selftest_o,
  input wire logic loop_defaults_o,
  input wire logic matrix_ready_o,
  input wire logic error_o,
  input wire logic lamps_all_o,
  input wire logic [6:0] bus_addr_o,
  input wire logic master_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] age;
  logic [6:0] sw_q;
  logic [15:0] low_cnt;
  logic ctrl_wr;
  assign ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == RSS_OFS_CTRL;
  // Switch copy taken just after release; the strap settles a few edges later
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      age <= 3'd0;
      sw_q <= 7'h00;
      low_cnt <= 16'h0000;
    end else begin
      if (age == 3'd0) sw_q <= addr_switch_i;
      if (age != 3'd7) age <= age + 3'd1;
      low_cnt <= matrix_ready_o ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  ready_drop_a: assert property (
    ctrl_wr && avs_writedata_i[RSS_CTRL_TRIG] |-> ##[1:2] !matrix_ready_o)
    else $error("ready stayed true after trigger");
  settle_floor_a: assert property (
    $rose(matrix_ready_o) |-> low_cnt >= card_settle_i) else $error("ready before settle");
  master_addr_a: assert property (
    age == 3'd7 && master_o |-> sw_q == bus_addr_o + RSS_ADDR_MASTER_OFS)
    else $error("master address wrong");
  solo_addr_a: assert property (
    age == 3'd7 && sw_q <= 7'd30 |-> bus_addr_o == sw_q && !master_o)
    else $error("stand-alone address wrong");
  addr_hold_a: assert property (
    age == 3'd7 |=> $stable(bus_addr_o)) else $error("address moved");
  lamp_test_a: assert property (
    age == 3'd7 && sw_q == RSS_ADDR_LAMP_TEST |-> lamps_all_o) else $error("lamps not lit");
  err_hold_a: assert property (
    error_o && !avs_read_i && !avs_write_i |=> error_o) else $error("error dropped early");
  overrun_err_a: assert property (
    ctrl_wr && avs_writedata_i[RSS_CTRL_TRIG] && !matrix_ready_o |-> ##[1:2] error_o)
    else $error("overrun without error");
  defaults_loop_a: assert property (
    ctrl_wr && avs_writedata_i[RSS_CTRL_DEFAULTS] && master_o |-> ##[1:2] loop_defaults_o)
    else $error("defaults not sent to loop");
  selftest_loop_a: assert property (
    ctrl_wr && avs_writedata_i[RSS_CTRL_SELFTEST] && master_o |-> ##[1:2] loop_selftest_o)
    else $error("self-test not sent to loop");
endmodule // rss_seq_checker
bind rss_sequencer rss_seq_checker i_rss_seq_checker (.clk_i, .nrst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o, .addr_switch_i,
  .card_settle_i, .loop_selftest_o, .loop_defaults_o, .matrix_ready_o, .error_o,
  .lamps_all_o, .bus_addr_o, .master_o);
`default_nettype wire

// >>> verification/rss_card_model.sv
// Relay card side model: settle time and ready-low length monitor
`timescale 1ns/100ps
`default_nettype none
module rss_card_model #(
  parameter logic [15:0] SETTLE = 16'h0003
) (
  // Clock
  input wire logic clk_i,
  // Ready from the sequencer
  input wire logic matrix_ready_i,
  // Card data and measurement
  output logic [15:0] card_settle_o,
  output logic [15:0] low_len_o
);
  logic [15:0] cnt = 16'h0000;
  assign card_settle_o = SETTLE;
  initial low_len_o = 16'h0000;
  // Length of the last low period, so phase counts need no relay data
  always @(posedge clk_i) begin
    if (matrix_ready_i) begin
      if (cnt != 16'h0000) low_len_o <= cnt;
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule // rss_card_model
`default_nettype wire

// >>> verification/rss_sequencer_bench.sv
// Testbench for the relay switch sequencer
`timescale 1ns/100ps
`default_nettype none
module rss_sequencer_bench
  import rss_pkg::*;
;
  localparam int TICK = 4;
  localparam int PH = 4;
  logic clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o, mem_test_ok_i;
  logic matrix_ready_o, error_o, lamps_all_o, master_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [6:0] addr_switch_i, bus_addr_o, ea;
  logic [6:0] sw_tab [7] = '{7'h12, 7'h00, 7'h1E, 7'h1F, 7'h3C, 7'h3D, 7'h63};
  logic [15:0] card_settle_i, low_len;
  int fail_count, total_checks, d0, dx;
  int cycles = 0;
  rss_sequencer #(.TICK_CYCLES(TICK), .TEST_CYCLES(4)) i_rss_sequencer (.clk_i, .nrst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .addr_switch_i, .card_settle_i, .mem_test_ok_i, .relay_o(),
    .loop_modes_o(), .loop_selftest_o(), .loop_defaults_o(), .matrix_ready_o, .error_o,
    .lamps_all_o, .bus_addr_o, .master_o);
  rss_card_model i_rss_card_model (.clk_i, .matrix_ready_i(matrix_ready_o),
    .card_settle_o(card_settle_i), .low_len_o(low_len));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_i);
    while (matrix_ready_o !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 4000) chk("ready", 32'h1, 32'h0);
  endtask
  task automatic power_up(input logic [6:0] sw);
    nrst_i <= 1'b0;
    addr_switch_i <= sw;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    wait_ready();
  endtask
  // Low time of ready after one trigger, measured by the card model
  task automatic trig(output int d);
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0001);
    wait_ready();
    @(posedge clk_i);
    d = int'(low_len);
  endtask
  initial begin
    {nrst_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    addr_switch_i = 7'h2D;
    mem_test_ok_i = 1'b1;
    {fail_count, total_checks} = '0;
    power_up(7'h2D);
    xfer(1'b0, RSS_OFS_HWSETTLE, 32'h0);
    chk("hw settle", {16'h0000, card_settle_i}, q);
    xfer(1'b1, RSS_OFS_DELAY, {16'h0000, RSS_DELAY_MAX});
    xfer(1'b0, RSS_OFS_DELAY, 32'h0);
    chk("delay max", {16'h0000, RSS_DELAY_MAX}, q);
    xfer(1'b0, RSS_OFS_MACHINE, 32'h0);
    chk("machine word", {RSS_DELAY_MAX, 8'h00, 1'b1, 7'h0F}, q);
    xfer(1'b0, 6'h3C, 32'h0);
    chk("unmapped read", RSS_RD_UNMAPPED, q);
    xfer(1'b1, RSS_OFS_DELAY, 32'h0);
    $display("test registers done");
    trig(d0);
    xfer(1'b1, RSS_OFS_ROWSEL, 32'h0000_0500);
    trig(dx);
    chk("mbb phases", d0 + PH, dx);
    xfer(1'b1, RSS_OFS_ROWSEL, 32'h0000_0601);
    trig(dx);
    chk("all phases", d0 + 3 * PH, dx);
    xfer(1'b1, RSS_OFS_ROWSEL, 32'h0000_0600);
    trig(dx);
    chk("mode replaced", d0 + PH, dx);
    xfer(1'b1, RSS_OFS_ROWSEL, 32'h0000_0200);
    xfer(1'b1, RSS_OFS_ROWSEL, 32'h0000_0201);
    trig(dx);
    chk("modes cleared", d0, dx);
    xfer(1'b1, RSS_OFS_DELAY, 32'h0000_0002);
    trig(dx);
    chk("ms delay", d0 + 2 * TICK, dx);
    $display("test phases done");
    xfer(1'b1, RSS_OFS_DELAY, 32'h0000_0003);
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0001);
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("overrun error", 32'h1, {31'h0, error_o});
    wait_ready();
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0008);
    chk("error cleared", 32'h0, {31'h0, error_o});
    $display("test overrun done");
    mem_test_ok_i <= 1'b0;
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0002);
    repeat (8) @(posedge clk_i);
    mem_test_ok_i <= 1'b1;
    chk("memory fail", 32'h1, {31'h0, error_o});
    xfer(1'b0, RSS_OFS_STATUS, 32'h0);
    chk("error after access", 32'h0, {31'h0, error_o});
    xfer(1'b1, RSS_OFS_DELAY, 32'h0000_0005);
    xfer(1'b1, RSS_OFS_CTRL, 32'h0000_0004);
    xfer(1'b0, RSS_OFS_DELAY, 32'h0);
    chk("defaults delay", {16'h0000, RSS_DELAY_RESET}, q);
    $display("test self-test done");
    foreach (sw_tab[i]) begin
      power_up(sw_tab[i]);
      ea = sw_tab[i] > 7'd60 ? RSS_ADDR_DEFAULT : sw_tab[i];
      if (sw_tab[i] > 7'd30 && sw_tab[i] <= 7'd60) ea = sw_tab[i] - RSS_ADDR_MASTER_OFS;
      chk("bus address", {25'h0, ea}, {25'h0, bus_addr_o});
      chk("master", {31'h0, sw_tab[i] > 7'd30 && sw_tab[i] <= 7'd60}, {31'h0, master_o});
      chk("lamps", {31'h0, sw_tab[i] == 7'd99}, {31'h0, lamps_all_o});
      addr_switch_i <= 7'h05;
      repeat (4) @(posedge clk_i);
      chk("address held", {25'h0, ea}, {25'h0, bus_addr_o});
    end
    $display("test strap done");
    conclude();
  end
endmodule // rss_sequencer_bench
`default_nettype wire
